// file: verilog/pst_bank.sv
/*
 Register bank for synthesizer settling times, invalid-preamble threshold,
 amplifier boost controls and the upper digital test-bus selections.
 Assumes a simple strobe register port on clk, and internal status inputs
 already in the clk domain.
*/
`timescale 1ns/1ns
`include "pst_map.svh"

// Functional notes
// - A cold start waits the soft settling time followed by the post-calibration time.
// - Bits 7:3 of the settle register give the retune wait, 0 to 310 us in 10 us steps.
// - The soft settling field resets to 100 us.
// - Bits 2:0 give the post-calibration wait, 0 to 70 us in 10 us steps.
// - The post-calibration field resets to 20 us.
// - Bits 5:2 of the boost register set the bad-preamble window, threshold times 4 bits.
// - Select 52 shows sync found, CRC error and header error on the three test pins.
// - Select 49 shows handler enable, valid preamble and packet searching.
// - Select 44 shows gated modulator clock, transmit clock and transmit clock over 10.
module pst_bank
	import pst_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Settling control from the core
	input wire logic settle_start,
	input wire pst_mode_t settle_mode,
	output logic settle_busy,
	output logic settle_done,
	// Preamble evaluation
	input wire logic bit_tick,
	input wire logic pre_start,
	output logic pre_active,
	output logic pre_expired,
	// Amplifier boosts
	output logic amp_regulator_boost,
	output logic amp_bias_boost,
	// Receive handler signals
	input wire logic rx_handler_enable,
	input wire logic preamble_valid,
	input wire logic packet_searching,
	input wire logic sync_found,
	input wire logic crc_error,
	input wire logic header_error,
	// Transmit clocks
	input wire logic mod_clock_gated,
	input wire logic tx_clock,
	// Pin routing (set elsewhere by software)
	input wire logic [2:0] pin_test_route,
	// Test pins
	output logic [2:0] test_pin
);
	pst_cfg_if cfg ();
	logic [7:0] settle_reg;
	logic [7:0] next_settle_reg;
	logic [7:0] boost_reg;
	logic [7:0] next_boost_reg;
	logic [5:0] tbus_sel;
	logic [5:0] next_tbus_sel;
	logic [7:0] next_rdata;
	logic us_tick;
	logic tx_clk_q;
	logic [3:0] div_cnt;
	logic [3:0] next_div_cnt;
	logic fifo_read_clock;
	logic next_fifo_read_clock;
	logic [2:0] next_test_pin;
	logic [2:0] mux_val;

	// ----------------------------------------
	// Register file
	// ----------------------------------------

	// Write decode
	always_comb
	begin
		next_settle_reg = settle_reg;
		next_boost_reg = boost_reg;
		next_tbus_sel = tbus_sel;
		if (reg_wr)
		begin
			unique case (reg_addr)
				`PST_ADDR_SETTLE: next_settle_reg = reg_wdata;
				`PST_ADDR_BOOST: next_boost_reg = reg_wdata;
				`PST_ADDR_TBUS: next_tbus_sel = reg_wdata[`PST_TBUS_HI:`PST_TBUS_LO];
				default: next_tbus_sel = tbus_sel;
			endcase
		end
	end

	// Read decode; unmapped addresses read zero
	always_comb
	begin
		next_rdata = 8'h00;
		if (reg_rd)
		begin
			unique case (reg_addr)
				`PST_ADDR_SETTLE: next_rdata = settle_reg;
				`PST_ADDR_BOOST: next_rdata = boost_reg;
				`PST_ADDR_TBUS: next_rdata = {2'b00, tbus_sel};
				`PST_ADDR_STATUS: next_rdata = {4'h0, pre_expired, pre_active,
					settle_done, settle_busy};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// Registers and read data; resets give 100 us and 20 us
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			settle_reg <= `PST_RST_SETTLE;
			boost_reg <= `PST_RST_BOOST;
			tbus_sel <= 6'(`PST_RST_TBUS);
			reg_rdata <= 8'h00;
		end
		else
		begin
			settle_reg <= next_settle_reg;
			boost_reg <= next_boost_reg;
			tbus_sel <= next_tbus_sel;
			reg_rdata <= next_rdata;
		end
	end

	// Field fan-out
	assign cfg.soft_settle_time = settle_reg[`PST_SOFT_HI:`PST_SOFT_LO];
	assign cfg.postcal_settle_time = settle_reg[`PST_POST_HI:`PST_POST_LO];
	assign cfg.bad_preamble_threshold = boost_reg[`PST_THR_HI:`PST_THR_LO];
	assign amp_regulator_boost = boost_reg[`PST_REG_BOOST_BIT];
	assign amp_bias_boost = boost_reg[`PST_BIAS_BOOST_BIT];

	// ----------------------------------------
	// Timers
	// ----------------------------------------

	pst_us_tick u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.us_tick(us_tick)
	);

	pst_settle_timer u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.us_tick(us_tick),
		.bit_tick(bit_tick),
		.cfg(cfg.timer),
		.settle_start(settle_start),
		.settle_mode(settle_mode),
		.settle_busy(settle_busy),
		.settle_done(settle_done),
		.pre_start(pre_start),
		.pre_active(pre_active),
		.pre_expired(pre_expired)
	);

	// ----------------------------------------
	// Test bus
	// ----------------------------------------

	// Read clock: toggles every 5 transmit clock rising edges, giving tx_clock / 10
	always_comb
	begin
		next_div_cnt = div_cnt;
		next_fifo_read_clock = fifo_read_clock;
		if (tx_clock && !tx_clk_q)
		begin
			if (div_cnt == 4'((`PST_READ_DIV / 2) - 1))
			begin
				next_div_cnt = 4'h0;
				next_fifo_read_clock = !fifo_read_clock;
			end
			else
				next_div_cnt = div_cnt + 4'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_clk_q <= 1'b0;
			div_cnt <= 4'h0;
			fifo_read_clock <= 1'b0;
		end
		else
		begin
			tx_clk_q <= tx_clock;
			div_cnt <= next_div_cnt;
			fifo_read_clock <= next_fifo_read_clock;
		end
	end

	// Select mux; codes not handled here drive low
	always_comb
	begin
		unique case (tbus_sel)
			`PST_TB_ERRORS: mux_val = {header_error, crc_error, sync_found};
			`PST_TB_RXPH: mux_val = {packet_searching, preamble_valid,
				rx_handler_enable};
			`PST_TB_CLOCKS: mux_val = {fifo_read_clock, tx_clock, mod_clock_gated};
			default: mux_val = 3'h0;
		endcase
		next_test_pin = mux_val & pin_test_route;
	end

	// Registered pins; clocks on the bus are sampled at clk rate
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			test_pin <= 3'h0;
		else
			test_pin <= next_test_pin;
	end
endmodule // pst_bank

// file: verilog/pst_map.svh
/*
 Address map, field positions, reset values and timing constants for the
 synthesizer settling and preamble-window register bank.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef PST_MAP_SVH
`define PST_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PST_ADDR_SETTLE 8'h53
`define PST_ADDR_BOOST 8'h54
`define PST_ADDR_TBUS 8'h60
`define PST_ADDR_CTRL 8'h61
`define PST_ADDR_STATUS 8'h62

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PST_RST_SETTLE 8'h52
`define PST_RST_BOOST 8'h54
`define PST_RST_TBUS 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PST_SOFT_HI 7
`define PST_SOFT_LO 3
`define PST_POST_HI 2
`define PST_POST_LO 0
`define PST_THR_HI 5
`define PST_THR_LO 2
`define PST_REG_BOOST_BIT 1
`define PST_BIAS_BOOST_BIT 0
`define PST_TBUS_HI 5
`define PST_TBUS_LO 0

// ----------------------------------------
// Test-bus select codes
// ----------------------------------------
`define PST_TB_CLOCKS 6'h2c
`define PST_TB_RXPH 6'h31
`define PST_TB_ERRORS 6'h34

// ----------------------------------------
// Timing
// ----------------------------------------
`define PST_CLK_HZ 10000000
`define PST_US_PER_S 1000000
`define PST_US_CYCLES (`PST_CLK_HZ / `PST_US_PER_S)
`define PST_STEP_US 10
`define PST_PRE_BITS_PER_STEP 4
`define PST_READ_DIV 10

`endif

// file: verilog/pst_pkg.sv
/*
 Types shared by the settling bank modules.
 Assumes pst_map.svh supplies the numeric constants.
*/
package pst_pkg;
	// Settling sequencer states
	typedef enum logic [1:0] {PST_IDLE, PST_SOFT, PST_POST} pst_state_t;
	// Timer mode requested by the core
	typedef enum logic [1:0] {PST_MODE_RETUNE, PST_MODE_POSTCAL, PST_MODE_COLD} pst_mode_t;
endpackage

// file: verilog/pst_cfg_if.sv
/*
 Configuration carrier from the register bank to the settling timer.
 Assumes a single clock domain.
*/
`timescale 1ns/1ns
interface pst_cfg_if;
	logic [4:0] soft_settle_time;
	logic [2:0] postcal_settle_time;
	logic [3:0] bad_preamble_threshold;
	modport bank (output soft_settle_time, output postcal_settle_time,
		output bad_preamble_threshold);
	modport timer (input soft_settle_time, input postcal_settle_time,
		input bad_preamble_threshold);
endinterface

// file: verilog/pst_us_tick.sv
/*
 Microsecond tick divider: one-cycle pulse every microsecond of clk.
 Assumes clk at the rate set in pst_map.svh.
*/
`timescale 1ns/1ns
`include "pst_map.svh"
module pst_us_tick
	import pst_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Tick out
	output logic us_tick
);
	localparam logic [7:0] LAST = 8'((`PST_US_CYCLES) - 1);
	logic [7:0] cnt;
	logic [7:0] next_cnt;

	// Wrap counter, tick on the last count
	always_comb
	begin
		next_cnt = (cnt == LAST) ? 8'h00 : cnt + 8'h01;
		us_tick = (cnt == LAST);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cnt <= 8'h00;
		else
			cnt <= next_cnt;
	end
endmodule // pst_us_tick

// file: verilog/pst_settle_timer.sv
/*
 Synthesizer settling timer and invalid-preamble window counter.
 Assumes a microsecond tick and a bit-period tick from the same clock.
*/
`timescale 1ns/1ns
`include "pst_map.svh"
module pst_settle_timer
	import pst_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Timebases
	input wire logic us_tick,
	input wire logic bit_tick,
	// Configuration
	pst_cfg_if.timer cfg,
	// Settling control
	input wire logic settle_start,
	input wire pst_mode_t settle_mode,
	output logic settle_busy,
	output logic settle_done,
	// Preamble window
	input wire logic pre_start,
	output logic pre_active,
	output logic pre_expired
);
	pst_state_t state;
	pst_state_t next_state;
	logic [8:0] us_left;
	logic [8:0] next_us_left;
	logic next_done;
	logic [5:0] pre_left;
	logic [5:0] next_pre_left;
	logic next_pre_exp;

	// Field value times step size, in microseconds
	function automatic logic [8:0] to_us(input logic [4:0] steps);
		to_us = 9'(steps * `PST_STEP_US);
	endfunction

	// Soft phase then post phase; cold start runs both in turn
	always_comb
	begin
		next_state = state;
		next_us_left = us_left;
		next_done = 1'b0;
		if (settle_start)
		begin
			unique case (settle_mode)
				PST_MODE_POSTCAL:
				begin
					next_state = PST_POST;
					next_us_left = to_us({2'b00, cfg.postcal_settle_time});
				end
				default:
				begin
					next_state = PST_SOFT;
					next_us_left = to_us(cfg.soft_settle_time);
				end
			endcase
		end
		else if (state != PST_IDLE)
		begin
			if (us_left == 9'h000)
			begin
				if (state == PST_SOFT && settle_mode == PST_MODE_COLD)
				begin
					next_state = PST_POST;
					next_us_left = to_us({2'b00, cfg.postcal_settle_time});
				end
				else
				begin
					next_state = PST_IDLE;
					next_done = 1'b1;
				end
			end
			else if (us_tick)
				next_us_left = us_left - 9'h001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state <= PST_IDLE;
			us_left <= 9'h000;
			settle_done <= 1'b0;
		end
		else
		begin
			state <= next_state;
			us_left <= next_us_left;
			settle_done <= next_done;
		end
	end

	assign settle_busy = (state != PST_IDLE);

	// Window of threshold x 4 bit periods
	always_comb
	begin
		next_pre_left = pre_left;
		next_pre_exp = 1'b0;
		if (pre_start)
			next_pre_left = 6'(cfg.bad_preamble_threshold * `PST_PRE_BITS_PER_STEP);
		else if (pre_left != 6'h00 && bit_tick)
		begin
			next_pre_left = pre_left - 6'h01;
			next_pre_exp = (pre_left == 6'h01);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pre_left <= 6'h00;
			pre_expired <= 1'b0;
		end
		else
		begin
			pre_left <= next_pre_left;
			pre_expired <= next_pre_exp;
		end
	end

	assign pre_active = (pre_left != 6'h00);
endmodule // pst_settle_timer

// file: dv/pst_bank_monitor.sv
/*
 Port checks for the settling register bank.
 Assumes binding to pst_bank, one clock, synchronous active-low reset.
*/
`timescale 1ns/1ns
`include "pst_map.svh"
module pst_bank_monitor
	import pst_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	// Settling
	input wire logic settle_start,
	input wire logic settle_busy,
	input wire logic settle_done,
	input wire logic pre_expired,
	// Boosts and test pins
	input wire logic amp_regulator_boost,
	input wire logic amp_bias_boost,
	input wire logic [2:0] test_pin,
	input wire logic [2:0] pin_test_route,
	// Test-bus sources
	input wire logic rx_handler_enable,
	input wire logic preamble_valid,
	input wire logic packet_searching,
	input wire logic sync_found,
	input wire logic crc_error,
	input wire logic header_error,
	input wire logic mod_clock_gated,
	input wire logic tx_clock
);
	logic [5:0] sel;
	logic [5:0] next_sel;
	logic [11:0] busy_cnt;
	logic [11:0] next_busy_cnt;
	// Select mirror, so mux checks know the code in force
	always_comb
	begin
		next_sel = (reg_wr && reg_addr == `PST_ADDR_TBUS) ? reg_wdata[5:0] : sel;
		next_busy_cnt = settle_busy ? busy_cnt + 12'h001 : 12'h000;
	end
	// Registers only
	always_ff @(posedge clk)
	begin
		sel <= rst_n ? next_sel : 6'h00;
		busy_cnt <= rst_n ? next_busy_cnt : 12'h000;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence busy_end;
		settle_busy ##1 !settle_busy;
	endsequence
	boost_follow_a: assert property (reg_wr && reg_addr == `PST_ADDR_BOOST |=>
		{amp_regulator_boost, amp_bias_boost} == $past(reg_wdata[1:0]))
		else $error("boost bits do not follow the write");
	settle_launch_a: assert property (settle_start |=> settle_busy || settle_done)
		else $error("settling did not start");
	done_after_busy_a: assert property (busy_end |-> settle_done)
		else $error("busy fell without done");
	done_single_a: assert property (settle_done |=> !settle_done)
		else $error("done longer than one cycle");
	// Longest cold start is 380 us plus tick phase
	settle_bound_a: assert property (busy_cnt <= 12'hef6)
		else $error("settling ran too long");
	expire_single_a: assert property (pre_expired |=> !pre_expired)
		else $error("window expiry longer than one cycle");
	err_pins_a: assert property (sel == `PST_TB_ERRORS |=>
		test_pin == $past({header_error, crc_error, sync_found} & pin_test_route))
		else $error("error code pins wrong");
	rx_pins_a: assert property (sel == `PST_TB_RXPH |=> test_pin ==
		$past({packet_searching, preamble_valid, rx_handler_enable} & pin_test_route))
		else $error("receive code pins wrong");
	clk_pins_a: assert property (sel == `PST_TB_CLOCKS |=>
		test_pin[1:0] == $past({tx_clock, mod_clock_gated} & pin_test_route[1:0]))
		else $error("clock code pins wrong");
	route_gate_a: assert property (pin_test_route == 3'h0 |=> test_pin == 3'h0)
		else $error("unrouted pin driven");
endmodule // pst_bank_monitor

// file: dv/pst_bank_test.sv
/*
 Self-checking bench for the settling register bank.
 Assumes the design files and pst_bank_monitor are compiled first.
*/
`timescale 1ns/1ns
`include "pst_map.svh"
module pst_bank_test
	import pst_pkg::*;
;
	logic clk, rst_n, reg_wr, reg_rd, settle_start, bit_tick, pre_start, tx_clock, pin_prev;
	logic settle_busy, settle_done, pre_active, pre_expired, amp_regulator_boost, amp_bias_boost;
	logic rx_handler_enable, preamble_valid, packet_searching, sync_found, crc_error;
	logic header_error, mod_clock_gated;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [2:0] pin_test_route, test_pin;
	logic [5:0] srcs;
	pst_mode_t settle_mode;
	int fail_count, compares, cycles, n, k;
	assign {header_error, crc_error, sync_found} = srcs[5:3];
	assign {packet_searching, preamble_valid, rx_handler_enable} = srcs[2:0];
	assign mod_clock_gated = srcs[1];
	pst_bank i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.settle_start, .settle_mode, .settle_busy, .settle_done, .bit_tick, .pre_start,
		.pre_active, .pre_expired, .amp_regulator_boost, .amp_bias_boost, .rx_handler_enable,
		.preamble_valid, .packet_searching, .sync_found, .crc_error, .header_error,
		.mod_clock_gated, .tx_clock, .pin_test_route, .test_pin);
	// 10 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Moving sources; tx clock at half the system rate
	always @(posedge clk)
	begin
		srcs <= srcs + 6'h01;
		tx_clock <= ~tx_clock;
		cycles++;
		if (cycles == 12000)
		begin
			fail_count++;
			close_out();
		end
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", reg_rdata, exp);
	endtask
	// Window slack covers the microsecond tick phase
	task automatic settle(input pst_mode_t m, input logic [7:0] cfg);
		int t;
		t = (m == PST_MODE_POSTCAL) ? 0 : 100 * cfg[7:3];
		if (m != PST_MODE_RETUNE)
			t = t + 100 * cfg[2:0];
		@(posedge clk);
		settle_mode <= m;
		settle_start <= 1'b1;
		@(posedge clk);
		settle_start <= 1'b0;
		n = 0;
		while (settle_done !== 1'b1 && n < 5000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		check("settle_cycles", n >= t - 10 && n <= t + 15, 1'b1);
	endtask
	task automatic window(input int ticks);
		int seen;
		seen = 0;
		@(posedge clk);
		pre_start <= 1'b1;
		@(posedge clk);
		pre_start <= 1'b0;
		#1;
		check("pre_active", pre_active, 1'b1);
		for (int j = 1; j <= ticks + 4 && seen == 0; j++)
		begin
			@(posedge clk);
			bit_tick <= 1'b1;
			repeat (3)
			begin
				@(posedge clk);
				bit_tick <= 1'b0;
				#1;
				if (pre_expired === 1'b1 && seen == 0)
					seen = j;
			end
		end
		check("window_ticks", seen, ticks);
		check("pre_active_end", pre_active, 1'b0);
	endtask
	task automatic close_out();
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		{reg_wr, reg_rd, settle_start, bit_tick, pre_start, tx_clock} = 6'h00;
		{reg_addr, reg_wdata, srcs, pin_test_route} = 25'h0000000;
		settle_mode = PST_MODE_RETUNE;
		rst_n = 1'b0;
		{fail_count, compares, cycles} = {32'h0, 32'h0, 32'h0};
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(`PST_ADDR_SETTLE, `PST_RST_SETTLE);
		rd(`PST_ADDR_BOOST, `PST_RST_BOOST);
		rd(8'h61, 8'h00);
		rd(`PST_ADDR_STATUS, 8'h00);
		wr(8'h70, 8'hff);
		rd(8'hff, 8'h00);
		for (k = 0; k < 3; k++)
			settle(pst_mode_t'(k), `PST_RST_SETTLE);
		wr(`PST_ADDR_SETTLE, 8'hff);
		settle(PST_MODE_COLD, 8'hff);
		wr(`PST_ADDR_SETTLE, 8'h00);
		settle(PST_MODE_RETUNE, 8'h00);
		wr(`PST_ADDR_BOOST, 8'h3f);
		rd(`PST_ADDR_BOOST, 8'h3f);
		window(60);
		wr(`PST_ADDR_BOOST, 8'h0a);
		#1;
		check("boosts", {amp_regulator_boost, amp_bias_boost}, 2'h2);
		window(8);
		@(posedge clk);
		pin_test_route <= 3'h7;
		wr(`PST_ADDR_TBUS, {2'h0, `PST_TB_ERRORS});
		repeat (40) @(posedge clk);
		wr(`PST_ADDR_TBUS, {2'h0, `PST_TB_RXPH});
		repeat (40) @(posedge clk);
		wr(`PST_ADDR_TBUS, {2'h0, `PST_TB_CLOCKS});
		repeat (40) @(posedge clk);
		#1;
		pin_prev = test_pin[2];
		n = 0;
		repeat (200)
		begin
			@(posedge clk);
			#1;
			if (test_pin[2] === 1'b1 && pin_prev === 1'b0)
				n++;
			pin_prev = test_pin[2];
		end
		check("read_clock_rises", n, 10);
		@(posedge clk);
		pin_test_route <= 3'h0;
		repeat (3) @(posedge clk);
		#1;
		check("test_pin", test_pin, 3'h0);
		close_out();
	end
endmodule // pst_bank_test
bind pst_bank pst_bank_monitor i_mon (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
	.settle_start, .settle_busy, .settle_done, .pre_expired, .amp_regulator_boost,
	.amp_bias_boost, .test_pin, .pin_test_route, .rx_handler_enable, .preamble_valid,
	.packet_searching, .sync_found, .crc_error, .header_error, .mod_clock_gated, .tx_clock);
